// File: shared/prsd_cfg.svh
`ifndef PRSD_CFG_SVH
`define PRSD_CFG_SVH
// Register byte offsets (word aligned copy of 0xe2 sits at 0xe0 word, lane 2)
`define PRSD_OFF_READBACK   8'he2
`define PRSD_OFF_MODE       8'he4
`define PRSD_OFF_MULT       8'he8
`define PRSD_OFF_CTRL       8'hec
// Readback field: strap value in bits 7:4 (top four strap bits)
`define PRSD_RB_LSB         4
`define PRSD_RB_MSB         7
// Multipliers kept in half units (x2), 4 bits each
`define PRSD_MULT_W         4
// Control register reset value
`define PRSD_CTRL_RST       32'h0000_0000
`endif

// File: shared/prsd_pkg.sv
package prsd_pkg;
  typedef enum logic [4:0] {
    PRSD_MODE_PLL      = 5'h01,
    PRSD_MODE_BYPASS   = 5'h02,
    PRSD_MODE_DUAL     = 5'h04,
    PRSD_MODE_OFF      = 5'h08,
    PRSD_MODE_RESERVED = 5'h10
  } prsd_mode_e;
  typedef logic [3:0] prsd_mult_t;
endpackage : prsd_pkg

// File: design/prsd_decode.sv
`timescale 1ns/1ps
`include "prsd_cfg.svh"
module prsd_decode
  import prsd_pkg::*;
(
  input  wire logic [4:0] strap,
  output prsd_mode_e      mode,
  output prsd_mult_t      mem_mult_x2,
  output prsd_mult_t      cpu_mult_x2
);
  // Ratio table, multipliers held as twice the ratio
  always_comb begin
    mode        = PRSD_MODE_PLL;
    mem_mult_x2 = 4'h0;
    cpu_mult_x2 = 4'h0;
    case (strap)
      5'h17: begin mem_mult_x2 = 4'h8; cpu_mult_x2 = 4'h4; end
      5'h18: begin mem_mult_x2 = 4'h5; cpu_mult_x2 = 4'h6; end
      5'h19: begin mem_mult_x2 = 4'h4; cpu_mult_x2 = 4'h5; end
      5'h1a: begin mem_mult_x2 = 4'h2; cpu_mult_x2 = 4'h8; end
      5'h1b: begin mem_mult_x2 = 4'h4; cpu_mult_x2 = 4'h6; end
      5'h1c: begin mem_mult_x2 = 4'h3; cpu_mult_x2 = 4'h6; end
      5'h1d: begin mem_mult_x2 = 4'h3; cpu_mult_x2 = 4'h5; end
      5'h1e: begin mem_mult_x2 = 4'h4; cpu_mult_x2 = 4'h7; end
      5'h1f: mode = PRSD_MODE_OFF;
      5'h03: begin mode = PRSD_MODE_BYPASS; mem_mult_x2 = 4'h2; cpu_mult_x2 = 4'h4; end
      5'h06: begin mode = PRSD_MODE_DUAL; mem_mult_x2 = 4'h2; cpu_mult_x2 = 4'h2; end
      default: mode = PRSD_MODE_RESERVED;
    endcase
  end
endmodule : prsd_decode

// File: design/prsd_top.sv
`timescale 1ns/1ps
`include "prsd_cfg.svh"
// Operation
// - Each listed strap code maps to a fixed memory and core multiplier pair.
// - Code 11111 selects clock-off, and no internal clock is enabled.
// - Bits 7-4 at offset 0xe2 read back the top four bits of the applied strap setting.
// - Single bypass clocks the core from the bus reference, memory PLL off, bus 1:1.
// - Dual bypass clocks peripheral logic from the bus reference, memory PLL off, 1:1.
// - Dual bypass clocks the core from the oscillator 1:1 with the core PLL off.
module prsd_top
  import prsd_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [4:0]  strap_pins,
  output logic             mem_pll_en,
  output logic             cpu_pll_en,
  output logic             core_from_ref,
  output logic             core_from_osc,
  output logic             periph_from_ref,
  output logic             clocks_off,
  output logic             strap_reserved,
  output logic      [3:0]  mem_mult_x2,
  output logic      [3:0]  cpu_mult_x2,
  output logic             core_clk_en
);
  // Strap synchroniser; pins are outside the clock domain
  logic [4:0] strap_s1_ff;
  logic [4:0] strap_s2_ff;
  logic [4:0] strap_ff;
  logic       held_ff;
  logic       rst_s1_ff;
  logic       rst_s2_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_s1_ff <= 5'h00;
      strap_s2_ff <= 5'h00;
    end else begin
      strap_s1_ff <= strap_pins;
      strap_s2_ff <= strap_s1_ff;
    end
  end

  // Reset release delayed to let the synchroniser fill with live straps
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_ff <= 5'h00;
      held_ff  <= 1'b0;
    end else if (rst_s2_ff && !held_ff) begin
      strap_ff <= strap_s2_ff;
      held_ff  <= 1'b1;
    end
  end

  prsd_mode_e dec_mode;
  prsd_mult_t dec_mem;
  prsd_mult_t dec_cpu;

  prsd_decode u_decode (
    .strap       (strap_ff),
    .mode        (dec_mode),
    .mem_mult_x2 (dec_mem),
    .cpu_mult_x2 (dec_cpu)
  );

  // Clock steering registered from the held strap
  prsd_mode_e mode_ff;
  logic [3:0] mem_ff;
  logic [3:0] cpu_ff;
  logic       ctrl_gate_ff;
  logic       dec_valid_ff;
  // One strobe per decoded mode
  wire  logic is_pll  = mode_ff == PRSD_MODE_PLL;
  wire  logic is_byp  = mode_ff == PRSD_MODE_BYPASS;
  wire  logic is_dual = mode_ff == PRSD_MODE_DUAL;
  wire  logic is_off  = mode_ff == PRSD_MODE_OFF;
  wire  logic is_rsvd = mode_ff == PRSD_MODE_RESERVED;
  wire  logic run     = dec_valid_ff && !is_off && !is_rsvd;

  // Held strap reaches mode_ff one edge later; gate until then
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dec_valid_ff <= 1'b0;
    end else begin
      dec_valid_ff <= held_ff;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_ff <= PRSD_MODE_OFF;
      mem_ff  <= 4'h0;
      cpu_ff  <= 4'h0;
    end else begin
      mode_ff <= dec_mode;
      mem_ff  <= dec_mem;
      cpu_ff  <= dec_cpu;
    end
  end

  assign core_from_ref   = dec_valid_ff && is_byp;
  assign periph_from_ref = dec_valid_ff && is_dual;
  assign core_from_osc   = dec_valid_ff && is_dual;
  assign mem_pll_en      = run && is_pll;
  assign cpu_pll_en      = run && !is_dual;
  // clock off wins; reserved codes stop clocks too
  assign clocks_off      = !dec_valid_ff || is_off || is_rsvd;
  assign strap_reserved  = dec_valid_ff && is_rsvd;
  assign core_clk_en     = run && !ctrl_gate_ff;
  assign mem_mult_x2     = mem_ff;
  assign cpu_mult_x2     = cpu_ff;

  // AHB-Lite slave, zero wait states
  logic       ph_valid_ff;
  logic       ph_write_ff;
  logic [7:0] ph_addr_ff;
  wire  logic take = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_valid_ff <= 1'b0;
      ph_write_ff <= 1'b0;
      ph_addr_ff  <= 8'h00;
    end else begin
      ph_valid_ff <= take;
      ph_write_ff <= hwrite;
      ph_addr_ff  <= haddr;
    end
  end

  wire logic [7:0] word_addr = {ph_addr_ff[7:2], 2'b00};
  wire logic       sel_rb    = word_addr == {`PRSD_OFF_READBACK & 8'hfc};
  wire logic       sel_mode  = word_addr == `PRSD_OFF_MODE;
  wire logic       sel_mult  = word_addr == `PRSD_OFF_MULT;
  wire logic       sel_ctrl  = word_addr == `PRSD_OFF_CTRL;

  // Software core-clock gate
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_gate_ff <= 1'(`PRSD_CTRL_RST);
    end else if (ph_valid_ff && ph_write_ff && sel_ctrl) begin
      ctrl_gate_ff <= hwdata[0];
    end
  end

  // readback in byte 2 lanes at bits 7:4 of byte 0xe2
  wire logic [31:0] rb_word = {8'h00, strap_ff[4:1], 4'h0, 16'h0000};
  wire logic [31:0] rd_mux  =
    sel_rb   ? rb_word :
    sel_mode ? {27'h0, mode_ff} :
    sel_mult ? {24'h0, cpu_ff, mem_ff} :
    sel_ctrl ? {31'h0, ctrl_gate_ff} : 32'h0000_0000;

  assign hrdata    = (ph_valid_ff && !ph_write_ff) ? rd_mux : 32'h0000_0000;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
endmodule : prsd_top

// File: sim/prsd_top_monitor.sv
`timescale 1ns/1ps
module prsd_top_mon (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic        hready,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        mem_pll_en,
  input wire logic        cpu_pll_en,
  input wire logic        core_from_ref,
  input wire logic        core_from_osc,
  input wire logic        periph_from_ref,
  input wire logic        clocks_off,
  input wire logic        strap_reserved,
  input wire logic [3:0]  mem_mult_x2,
  input wire logic [3:0]  cpu_mult_x2,
  input wire logic        core_clk_en
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_ZERO_WAIT: assert property (hreadyout && !hresp) else $error("bus stall or error");
  AST_IDLE_RD: assert property (!$past(hsel && hready && htrans[1] && !hwrite) |-> hrdata == 0)
    else $error("read data outside data phase");
  AST_OFF_GATE: assert property (clocks_off |-> !core_clk_en && !mem_pll_en && !cpu_pll_en)
    else $error("clock running in off mode");
  AST_BYP: assert property (hresetn[*6] ##0 core_from_ref |-> !mem_pll_en && mem_mult_x2 == 2)
    else $error("bypass not 1:1");
  AST_DUAL_REF: assert property (hresetn[*6] ##0 periph_from_ref |-> !mem_pll_en && mem_mult_x2 == 2)
    else $error("dual bypass memory side wrong");
  AST_DUAL_OSC: assert property (hresetn[*6] ##0 core_from_osc |-> !cpu_pll_en && cpu_mult_x2 == 2)
    else $error("dual bypass core side wrong");
  AST_RSVD: assert property (strap_reserved |-> clocks_off) else $error("reserved code clocks");
  AST_PLL_MODE: assert property (mem_pll_en |-> !core_from_ref && !periph_from_ref && !clocks_off)
    else $error("pll mode mixed with bypass");
  AST_HOLD: assert property (hresetn[*6] |=> $stable({mem_mult_x2, cpu_mult_x2, clocks_off}))
    else $error("decode changed without reset");
endmodule : prsd_top_mon
bind prsd_top prsd_top_mon mon_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .hready(hready),
  .htrans(htrans), .hwrite(hwrite), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .mem_pll_en(mem_pll_en), .cpu_pll_en(cpu_pll_en), .core_from_ref(core_from_ref),
  .core_from_osc(core_from_osc), .periph_from_ref(periph_from_ref), .clocks_off(clocks_off),
  .strap_reserved(strap_reserved), .mem_mult_x2(mem_mult_x2), .cpu_mult_x2(cpu_mult_x2),
  .core_clk_en(core_clk_en));

// File: sim/prsd_board.sv
`timescale 1ns/1ps
module prsd_board (
  input  wire logic [4:0] code,
  output logic      [4:0] strap_pins
);
  // one bench clock serves both references, so they stay in step
  // reference frequency is not modelled; bench keeps it nominal
  // memory VCO range left to the chosen code and reference
  // core VCO and core clock range left to the chosen code
  assign strap_pins = code;
endmodule : prsd_board

// File: sim/tb.sv
`timescale 1ns/1ps
module tb;
  logic        hclk, hresetn, hsel, hwrite;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, rd;
  logic [4:0]  code;
  logic [17:0] e;
  wire  [31:0] hrdata;
  wire  [4:0]  strap_pins;
  wire         hreadyout, hresp, mpe, cfr, cfo, pfr, off, rsv, cpe, cce;
  wire  [3:0]  mmx, cmx;
  wire         hready = hreadyout;
  int          mismatches = 0, cmp_count = 0;
  // Entry: code, one-hot mode, core x2, memory x2
  logic [17:0] tbl [12] = '{{5'h17,5'h01,4'h4,4'h8}, {5'h18,5'h01,4'h6,4'h5},
    {5'h19,5'h01,4'h5,4'h4}, {5'h1a,5'h01,4'h8,4'h2}, {5'h1b,5'h01,4'h6,4'h4},
    {5'h1c,5'h01,4'h6,4'h3}, {5'h1d,5'h01,4'h5,4'h3}, {5'h1e,5'h01,4'h7,4'h4},
    {5'h03,5'h02,4'h4,4'h2}, {5'h06,5'h04,4'h2,4'h2}, {5'h1f,5'h08,4'h0,4'h0},
    {5'h05,5'h10,4'h0,4'h0}};
  prsd_board brd_u (.code(code), .strap_pins(strap_pins));
  prsd_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .strap_pins(strap_pins), .mem_pll_en(mpe),
    .cpu_pll_en(cpe), .core_from_ref(cfr), .core_from_osc(cfo), .periph_from_ref(pfr),
    .clocks_off(off), .strap_reserved(rsv), .mem_mult_x2(mmx), .cpu_mult_x2(cmx),
    .core_clk_en(cce));
  initial begin
    hclk = 0;
    forever #4 hclk = ~hclk;
  end
  task automatic ahb(input logic [7:0] a, input logic wr, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    // Read data taken at the edge that ends the data phase
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask : cmp
  task automatic end_sim;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim
  initial begin
    #100000;
    mismatches++;
    end_sim();
  end
  initial begin
    {hresetn, hsel, haddr, htrans, hwrite, hwdata} = '0;
    hsize = 3'h2;
    code = 5'h17;
    foreach (tbl[i]) begin
      e = tbl[i];
      hresetn <= 1'b0;
      code <= e[17:13];
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (6) @(posedge hclk);
      ahb(8'he0, 1'b1, 32'hffff_ffff);
      ahb(8'he0, 1'b0, 32'h0);
      cmp(rd[23:20], e[17:14], "readback");
      ahb(8'he4, 1'b0, 32'h0);
      cmp(rd, e[12:8], "mode");
      ahb(8'he8, 1'b0, 32'h0);
      if (!e[11] && !e[12]) cmp(rd, e[7:0], "multipliers");
      cmp({mpe, cfr, cfo, pfr, off, rsv}, {e[8], e[9], e[10], e[10], e[11] | e[12], e[12]},
          "clock routing");
      cmp({cmx, mmx}, e[7:0], "multiplier pins");
      cmp({cpe, cce}, {e[8] | e[9], e[8] | e[9] | e[10]}, "core enables");
      ahb(8'hec, 1'b1, 32'h0000_0001);
      ahb(8'hec, 1'b0, 32'h0);
      cmp(rd, 32'h0000_0001, "gate readback");
      cmp(cce, 1'b0, "core clock gated");
      ahb(8'h40, 1'b0, 32'h0);
      cmp(rd, 32'h0, "unmapped read");
      code <= (e[17:13] == 5'h17) ? 5'h18 : 5'h17;
      repeat (6) @(posedge hclk);
      ahb(8'he4, 1'b0, 32'h0);
      cmp(rd, e[12:8], "mode after strap change");
    end
    end_sim();
  end
endmodule : tb
